// *** rtl/nvm_ctrl_pkg.sv ***
/*
 * Constants and carrier types for the nonvolatile copy and lock control.
 * Assumes a single 10 MHz device clock and an upstream register access port
 * that presents byte-wide writes and reads at an 8-bit register address.
 */
// What this block does
// - Write-enable one copies selected bits to store
// - Write-enable clears itself when copy completes
// - Protect bit locks store after next copy
// - Locked store rejects all later writes
// - Lock status bit reads one when locked
// - Reserved low bits ignore written data
// - Reserved low bits always read zero
package nvm_ctrl_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] NVM_CONTROL_ADDR = 8'hFF;
    localparam int WEN_BIT = 7;
    localparam int WP_BIT = 6;
    localparam int LOCK_STATUS_BIT = 5;
    localparam logic [7:0] NVM_CONTROL_RESET = 8'h00;

    // ****************************************
    // Store geometry and timing
    // ****************************************
    localparam int STORE_WORDS = 8;
    localparam int STORE_WIDTH = 8;
    localparam int WORD_WRITE_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int WORD_WRITE_CYCLES =
        (WORD_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COPY = 3'b010,
        ST_DONE = 3'b100
    } copy_state_t;

endpackage

// *** rtl/nvm_store.sv ***
/*
 * Nonvolatile word array model with a write port that honours the lock.
 * Assumes its writer steps through words one at a time.
 */
`timescale 1ns/10ps
module nvm_store
    import nvm_ctrl_pkg::*;
#(
    parameter int WORDS = STORE_WORDS,
    parameter int WIDTH = STORE_WIDTH
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Write port
    input wire logic i_we,
    input wire logic i_locked,
    input wire logic [$clog2(WORDS)-1:0] i_addr,
    input wire logic [WIDTH-1:0] i_data,
    // Flat read of every word
    output logic [WORDS*WIDTH-1:0] o_words
);
    logic [WIDTH-1:0] mem [WORDS];
    logic [WIDTH-1:0] next_mem [WORDS];

    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            next_mem[i] = mem[i];
        end
        if (i_we && !i_locked) begin
            next_mem[i_addr] = i_data;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < WORDS; i++) begin
                mem[i] <= '0;
            end
        end else begin
            mem <= next_mem;
        end
    end

    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            o_words[i*WIDTH +: WIDTH] = mem[i];
        end
    end
endmodule // nvm_store

// *** rtl/nvm_copy_lock_control.sv ***
/*
 * Control register, copy sequencer and permanent lock for the store.
 * Assumes the register access port runs on i_sys_clk and that the
 * configuration register bits to save arrive as a flat vector.
 * Selection of which configuration bits are saved is made upstream.
 * Reset stands in for a fresh part: it clears the store and the lock.
 */
`timescale 1ns/10ps
module nvm_copy_lock_control
    import nvm_ctrl_pkg::*;
#(
    parameter int WORDS = STORE_WORDS,
    parameter int WIDTH = STORE_WIDTH
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Register access
    input wire reg_req_t i_req,
    output logic [7:0] o_rdata,
    // Configuration bits to save and saved defaults
    input wire logic [WORDS*WIDTH-1:0] i_cfg_bits,
    output logic [WORDS*WIDTH-1:0] o_stored_bits,
    // Status
    output logic o_copy_busy,
    output logic o_nvm_lock_status
);
    // ****************************************
    // Local sizes and state
    // ****************************************
    localparam int AW = $clog2(WORDS);
    localparam logic [AW-1:0] LAST_WORD = AW'(WORDS - 1);
    // Counter is 8 bits wide: at most 256 cycles per word
    localparam logic [7:0] WAIT_LAST = 8'(WORD_WRITE_CYCLES - 1);

    // Registered state
    copy_state_t state, next_state;
    logic wen, next_wen;
    logic wp, next_wp;
    logic locked, next_locked;
    logic lock_pending, next_lock_pending;
    logic [AW-1:0] word, next_word;
    logic [7:0] wait_cnt, next_wait_cnt;
    logic [7:0] rdata, next_rdata;

    // Strobes and data feed
    logic store_we;
    logic ctrl_wr;
    logic [WIDTH-1:0] word_data;

    assign ctrl_wr = i_req.wr && (i_req.addr == NVM_CONTROL_ADDR);

    // ****************************************
    // Control register
    // ****************************************
    always_comb begin
        next_wen = wen;
        next_wp = wp;
        // Only top bits stored
        // Writes are dropped mid-copy so the running sequence keeps its settings
        if (ctrl_wr && state == ST_IDLE) begin
            next_wen = i_req.wdata[WEN_BIT];
            next_wp = i_req.wdata[WP_BIT];
        end
        if (state == ST_DONE) begin
            next_wen = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wen <= NVM_CONTROL_RESET[WEN_BIT];
            wp <= NVM_CONTROL_RESET[WP_BIT];
        end else begin
            wen <= next_wen;
            wp <= next_wp;
        end
    end

    // ****************************************
    // Copy sequencer
    // ****************************************
    always_comb begin
        next_state = state;
        next_word = word;
        next_wait_cnt = wait_cnt;
        store_we = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (wen) begin
                    next_state = ST_COPY;
                    next_word = '0;
                    next_wait_cnt = '0;
                end
            end
            ST_COPY: begin
                // Wait out the cell write time before programming each word
                if (wait_cnt == WAIT_LAST) begin
                    store_we = !locked;
                    next_wait_cnt = '0;
                    if (word == LAST_WORD) begin
                        // Last word hands over to DONE, where enable and lock change together
                        next_state = ST_DONE;
                    end else begin
                        next_word = word + 1'b1;
                    end
                end else begin
                    next_wait_cnt = wait_cnt + 8'h01;
                end
            end
            ST_DONE: begin
                // One closing cycle, then back to idle
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= ST_IDLE;
            word <= '0;
            wait_cnt <= '0;
        end else begin
            state <= next_state;
            word <= next_word;
            wait_cnt <= next_wait_cnt;
        end
    end

    // ****************************************
    // Permanent lock
    // ****************************************
    always_comb begin
        next_locked = locked;
        next_lock_pending = lock_pending;
        // Protect bit is sampled as the copy starts, so the lock follows that copy
        if (state == ST_IDLE && wen) begin
            next_lock_pending = wp;
        end
        if (state == ST_DONE) begin
            if (lock_pending) begin
                next_locked = 1'b1;
            end
            next_lock_pending = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            locked <= NVM_CONTROL_RESET[LOCK_STATUS_BIT];
            lock_pending <= 1'b0;
        end else begin
            locked <= next_locked | locked;
            lock_pending <= next_lock_pending;
        end
    end

    // ****************************************
    // Word feed to the store
    // ****************************************
    // Live bits are read per word; a change mid-copy lands in later words
    // Hold the configuration bits steady for a consistent snapshot
    always_comb begin
        word_data = i_cfg_bits[word*WIDTH +: WIDTH];
    end

    // ****************************************
    // Read data
    // ****************************************
    always_comb begin
        next_rdata = rdata;
        if (i_req.rd) begin
            // Reserved bits read zero
            // Other addresses also read zero
            next_rdata = 8'h00;
            if (i_req.addr == NVM_CONTROL_ADDR) begin
                next_rdata[WEN_BIT] = wen;
                next_rdata[WP_BIT] = wp;
                next_rdata[LOCK_STATUS_BIT] = locked;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_rdata = rdata;
    // Busy also covers the closing cycle in which enable clears
    assign o_copy_busy = (state != ST_IDLE);
    // Lock flag feeds the status bit and the store's write gate
    assign o_nvm_lock_status = locked;

    // ****************************************
    // Store
    // ****************************************
    // Store checks the lock again, so no path can reach a locked cell
    nvm_store #(
        .WORDS(WORDS),
        .WIDTH(WIDTH)
    ) u_store (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_we(store_we),
        .i_locked(locked),
        .i_addr(word),
        .i_data(word_data),
        .o_words(o_stored_bits)
    );
endmodule // nvm_copy_lock_control

// *** verification/nvm_copy_lock_control_asserts.sv ***
/* Port checker for nvm_copy_lock_control.
   Assumes one clock and the bind below this module. */
`timescale 1ns/10ps
module nvm_copy_lock_control_checker
    import nvm_ctrl_pkg::*;
#(
    parameter int WORDS = STORE_WORDS,
    parameter int WIDTH = STORE_WIDTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire reg_req_t i_req,
    input wire logic [7:0] o_rdata,
    input wire logic [WORDS*WIDTH-1:0] o_stored_bits,
    input wire logic o_copy_busy,
    input wire logic o_nvm_lock_status
);
    int busy_cnt;
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) busy_cnt <= 0;
        else busy_cnt <= o_copy_busy ? busy_cnt + 1 : 0;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    property p_rsvd; o_rdata[4:0] == 5'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
    property p_start;
        i_req.wr && i_req.addr == NVM_CONTROL_ADDR && i_req.wdata[WEN_BIT] && !o_copy_busy
        |-> ##2 o_copy_busy;
    endproperty
    a_start: assert property (p_start) else $error("copy did not start");
    property p_len; $fell(o_copy_busy) |-> busy_cnt == WORDS*WORD_WRITE_CYCLES + 1; endproperty
    a_len: assert property (p_len) else $error("copy length wrong");
    property p_sticky; o_nvm_lock_status |=> o_nvm_lock_status; endproperty
    a_sticky: assert property (p_sticky) else $error("lock released");
    property p_lockend; $rose(o_nvm_lock_status) |-> $fell(o_copy_busy); endproperty
    a_lockend: assert property (p_lockend) else $error("lock not at copy end");
    property p_frozen; o_nvm_lock_status |=> $stable(o_stored_bits); endproperty
    a_frozen: assert property (p_frozen) else $error("locked store changed");
    property p_status;
        i_req.rd && i_req.addr == NVM_CONTROL_ADDR |=> o_rdata[5] == $past(o_nvm_lock_status);
    endproperty
    a_status: assert property (p_status) else $error("status bit wrong");
    property p_idle; (!o_copy_busy)[*2] |=> $stable(o_stored_bits); endproperty
    a_idle: assert property (p_idle) else $error("store changed while idle");
endmodule // nvm_copy_lock_control_checker
bind nvm_copy_lock_control nvm_copy_lock_control_checker #(.WORDS(WORDS), .WIDTH(WIDTH))
    checker_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_req(i_req), .o_rdata(o_rdata),
    .o_stored_bits(o_stored_bits), .o_copy_busy(o_copy_busy),
    .o_nvm_lock_status(o_nvm_lock_status));

// *** verification/nvm_copy_lock_control_tb_top.sv ***
/* Bench for nvm_copy_lock_control: register rows, copies, lock, reset.
   Assumes inputs driven on the falling edge of one 10 MHz clock. */
`timescale 1ns/10ps
module nvm_copy_lock_control_tb_top;
    import nvm_ctrl_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    reg_req_t i_req = '0;
    logic [63:0] i_cfg_bits = 64'h0;
    logic [7:0] o_rdata;
    logic [63:0] o_stored_bits;
    logic o_copy_busy;
    logic o_nvm_lock_status;
    logic [7:0] r;
    int miscompares = 0;
    int cmp_count = 0;
    // Written value beside expected readback; last row clears protect
    logic [7:0] rows [3][2] = '{'{8'h5F, 8'h40}, '{8'h7F, 8'h40}, '{8'h3F, 8'h00}};
    nvm_copy_lock_control nvm_copy_lock_control_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_req(i_req), .o_rdata(o_rdata), .i_cfg_bits(i_cfg_bits),
        .o_stored_bits(o_stored_bits), .o_copy_busy(o_copy_busy),
        .o_nvm_lock_status(o_nvm_lock_status));
    initial begin
        forever #50 i_sys_clk = ~i_sys_clk;
    end
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(negedge i_sys_clk);
        i_req = '{wr: 1'b1, rd: 1'b0, addr: NVM_CONTROL_ADDR, wdata: d};
        @(negedge i_sys_clk);
        i_req = '0;
    endtask
    // Data is taken a cycle and a half after the read edge, it holds until the next read
    task automatic rd(output logic [7:0] d);
        @(negedge i_sys_clk);
        i_req = '{wr: 1'b0, rd: 1'b1, addr: NVM_CONTROL_ADDR, wdata: 8'h00};
        @(negedge i_sys_clk);
        i_req = '0;
        @(negedge i_sys_clk);
        d = o_rdata;
    endtask
    task automatic copy(input logic [7:0] d, input logic [63:0] cfg);
        i_cfg_bits = cfg;
        wr(d);
        @(negedge i_sys_clk);
        chk(o_copy_busy, 1'b1);
        // Write landing mid-copy must be dropped
        wr(8'h00);
        r = 8'hFF;
        for (int n = 0; n < 100 && r[7] !== 1'b0; n++) rd(r);
        if (r[7] !== 1'b0) begin
            miscompares++;
            results();
        end
        $display("Copy with %h done", d);
    endtask
    initial begin
        repeat (6) @(negedge i_sys_clk);
        i_rst = 1'b0;
        for (int i = 0; i < 3; i++) begin
            wr(rows[i][0]);
            rd(r);
            chk(r, rows[i][1]);
            $display("Row %0d done", i);
        end
        copy(8'h80, 64'h0123456789ABCDEF);
        chk({o_copy_busy, o_nvm_lock_status, o_stored_bits}, {2'b00, 64'h0123456789ABCDEF});
        copy(8'hC0, 64'hFEDCBA9876543210);
        rd(r);
        chk({r, o_stored_bits}, {8'h60, 64'hFEDCBA9876543210});
        copy(8'h80, 64'h55AA55AA55AA55AA);
        chk({o_nvm_lock_status, o_stored_bits}, {1'b1, 64'hFEDCBA9876543210});
        @(negedge i_sys_clk);
        i_rst = 1'b1;
        @(negedge i_sys_clk);
        i_rst = 1'b0;
        rd(r);
        chk({o_nvm_lock_status, r, o_stored_bits}, 73'h0);
        $display("Reset test done");
        results();
    end
endmodule // nvm_copy_lock_control_tb_top
